// File: memctl_pkg.sv
package memctl_pkg;

  // register offsets (byte addresses on the ahb-lite slave)
  localparam logic [7:0] OFS_SPACE_WAIT0 = 8'h00;
  localparam logic [7:0] OFS_SPACE_CTRL0 = 8'h04;
  localparam logic [7:0] OFS_SPACE_MASK0 = 8'h08;
  localparam logic [7:0] OFS_SPACE_START0 = 8'h0C;
  localparam logic [7:0] OFS_SPACE_STRIDE = 8'h10;
  localparam logic [7:0] OFS_DEFAULT_WAIT = 8'h40;
  localparam logic [7:0] OFS_DEFAULT_CTRL = 8'h44;
  localparam logic [7:0] OFS_PAGE_ROM_CTRL = 8'h48;
  localparam logic [7:0] OFS_BUS_STATUS = 8'h4C;

  // field positions
  localparam int WW_LSB = 4;
  localparam int WR_LSB = 0;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_PROG_BIT = 6;
  localparam int CTRL_REC_BIT = 4;
  localparam int CTRL_TYPE_LSB = 2;
  localparam int CTRL_BUS_LSB = 0;
  localparam int PAGE_EN_BIT = 4;
  localparam int PAGE_CYC_LSB = 2;
  localparam int PAGE_SIZE_LSB = 0;

  // reset values
  localparam logic [7:0] RST_WAIT = 8'h22;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BOOT_CTRL = 8'h80;
  localparam logic [7:0] RST_START = 8'hFF;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_PAGE = 8'h02;

  // wait codes
  localparam logic [2:0] WAIT_2ST = 3'h1;
  localparam logic [2:0] WAIT_3ST = 3'h2;
  localparam logic [2:0] WAIT_PIN = 3'h3;
  localparam logic [2:0] WAIT_4ST = 3'h5;
  localparam logic [2:0] WAIT_5ST = 3'h6;
  localparam logic [2:0] WAIT_6ST = 3'h7;

  localparam logic [1:0] BUS_8 = 2'h0;
  localparam logic [1:0] BUS_16 = 2'h1;
  localparam logic [1:0] TYPE_SRAM = 2'h0;
  localparam int BOOT_SPACE = 2;
  localparam int NUM_SPACES = 4;
  localparam logic [2:0] SEL_DEFAULT = 3'h4;

  // one external access request from the core side
  typedef struct packed {
    logic [23:0] addr;
    logic [1:0] size;   // 0 byte, 1 half, 2 word
    logic write;
    logic [31:0] wdata;
  } mem_req_t;

  // decoded settings of the selected space
  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] wait_code;
    logic [1:0] bus_width;
    logic recovery;
    logic page;
  } space_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECOVER = 3'b001,
    ST_ACCESS = 3'b010,
    ST_NEXT = 3'b011
  } bus_state_t;

endpackage

// File: space_decoder.sv
module space_decoder (
  input wire logic [23:0] addr,
  input wire logic [7:0] start_bits,
  input wire logic [15:0] compare_mask,
  input wire logic enable,
  input wire logic whole_range,
  output logic hit
);
  import memctl_pkg::*;

  // only a23..a8 take part; low byte is never compared
  always_comb begin
    if (!enable) begin
      hit = 1'b0;
    end else if (whole_range) begin
      hit = 1'b1;
    end else begin
      hit = (((addr[23:8] ^ {start_bits, 8'h00}) & ~compare_mask) == 16'h0000);
    end
  end
endmodule // space_decoder

// File: wait_counter.sv
module wait_counter (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic page_fast,
  input wire logic [1:0] page_code,
  input wire logic wait_n,
  output logic last
);
  import memctl_pkg::*;

  logic [2:0] cnt_q, cnt_d;
  logic [2:0] total;

  always_comb begin
    if (page_fast) begin
      total = 3'(page_code) + 3'h1;
    end else begin
      case (code)
        WAIT_2ST: total = 3'h2;
        WAIT_4ST: total = 3'h4;
        WAIT_5ST: total = 3'h5;
        WAIT_6ST: total = 3'h6;
        default: total = 3'h3; // pin mode floor of 2 handled below; reserved treated as 3
      endcase
    end
  end

  // cnt counts states of the cycle, 1 = first state
  always_comb begin
    if (start) begin
      cnt_d = 3'h1;
    end else if (cnt_q != 3'h7) begin
      cnt_d = cnt_q + 3'h1;
    end else begin
      cnt_d = cnt_q;
    end
    if (!page_fast && code == WAIT_PIN) begin
      last = (cnt_q >= 3'h2) && wait_n;
    end else begin
      last = (cnt_q >= total);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // wait_counter

// File: memory_controller.sv
// Behaviour
// - unused read lanes ignored; unused write lanes floated, strobe inactive
// - a cycle without waits lasts two states, the minimum
// - wait codes 001,010,101,110,111 give 2..6 states; 011 is pin mode
// - all wait fields reset to code 010
// - pin mode extends while wait low; ends at state two if high
// - recovery bit inserts one dummy state before entering another space
// - page reads only in space two, when page enable set
// - page cycle code gives 1,2,3,4 state follow-on reads
// - page boundary ends burst; next page starts with normal access
// - page size code selects 64,32,16,8 bytes
// - bus width 00 is 8 bit, 01 is 16 bit
// - memory type 00 selects sram/rom, reset value
// - space two enable resets to one, others to zero
// - space two covers all addresses until its programmable bit set
// - space two bus width loaded from boot mode pins at reset
// - start registers give a23..a16, reset to all ones
// - mask bit zero compares, one excludes; reset all ones
// - space zero mask: single bits a20..a15, a8; one bit a14..a9
// - operands split into bus cycles, low bytes first
// - matching space drives its select low
// - lower numbered space wins on overlap
// - unmatched accesses use default space settings
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
module memory_controller (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] boot_mode_pins,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire memctl_pkg::mem_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [31:0] rdata,
  output logic rdata_valid,
  output logic [23:0] ext_addr,
  output logic [15:0] ext_data_out,
  output logic [1:0] ext_data_oe,
  input wire logic [15:0] ext_data_in,
  output logic rd_n,
  output logic [1:0] wr_n,
  input wire logic wait_n,
  output logic [3:0] space_select_out_n
);
  import memctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] wait_q [NUM_SPACES], wait_d [NUM_SPACES];
  logic [7:0] ctrl_q [NUM_SPACES], ctrl_d [NUM_SPACES];
  logic [7:0] mask_q [NUM_SPACES], mask_d [NUM_SPACES];
  logic [7:0] start_q [NUM_SPACES], start_d [NUM_SPACES];
  logic [7:0] dwait_q, dwait_d, dctrl_q, dctrl_d, page_q, page_d;
  logic boot_load_q, boot_load_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic bus_busy;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_comb begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    hrdata_d = hrdata_q;
    wait_d = wait_q;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    start_d = start_q;
    dwait_d = dwait_q;
    dctrl_d = dctrl_q;
    page_d = page_q;
    boot_load_d = 1'b0;
    if (boot_load_q) begin
      ctrl_d[BOOT_SPACE][CTRL_BUS_LSB +: 2] = boot_mode_pins;
    end
    if (wr_pend_q) begin
      // wait and control registers are write-only; start, mask, page control and bus status read back
      for (int i = 0; i < NUM_SPACES; i++) begin
        if (wr_addr_q == OFS_SPACE_WAIT0 + 8'(i) * OFS_SPACE_STRIDE) begin
          wait_d[i] = hwdata[7:0];
        end else if (wr_addr_q == OFS_SPACE_CTRL0 + 8'(i) * OFS_SPACE_STRIDE) begin
          ctrl_d[i] = hwdata[7:0];
          if (i != BOOT_SPACE) begin
            ctrl_d[i][CTRL_PROG_BIT] = 1'b0;
          end
        end else if (wr_addr_q == OFS_SPACE_MASK0 + 8'(i) * OFS_SPACE_STRIDE) begin
          mask_d[i] = hwdata[7:0];
        end else if (wr_addr_q == OFS_SPACE_START0 + 8'(i) * OFS_SPACE_STRIDE) begin
          start_d[i] = hwdata[7:0];
        end
      end
      if (wr_addr_q == OFS_DEFAULT_WAIT) begin
        dwait_d = hwdata[7:0];
      end else if (wr_addr_q == OFS_DEFAULT_CTRL) begin
        dctrl_d = hwdata[7:0];
      end else if (wr_addr_q == OFS_PAGE_ROM_CTRL) begin
        page_d = hwdata[7:0];
      end
    end
    if (hsel && hready && htrans[1]) begin
      wr_pend_d = hwrite;
      wr_addr_d = haddr[7:0];
      hrdata_d = 32'h0000_0000;
      if (!hwrite) begin
        for (int i = 0; i < NUM_SPACES; i++) begin
          if (haddr[7:0] == OFS_SPACE_MASK0 + 8'(i) * OFS_SPACE_STRIDE) begin
            hrdata_d = {24'h00_0000, mask_q[i]};
          end else if (haddr[7:0] == OFS_SPACE_START0 + 8'(i) * OFS_SPACE_STRIDE) begin
            hrdata_d = {24'h00_0000, start_q[i]};
          end
        end
        if (haddr[7:0] == OFS_PAGE_ROM_CTRL) begin
          hrdata_d = {24'h00_0000, page_q};
        end else if (haddr[7:0] == OFS_BUS_STATUS) begin
          hrdata_d = {27'h000_0000, bus_busy, ~space_select_out_n};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_SPACES; i++) begin
        wait_q[i] <= RST_WAIT;
        ctrl_q[i] <= (i == BOOT_SPACE) ? RST_BOOT_CTRL : RST_CTRL;
        mask_q[i] <= RST_MASK;
        start_q[i] <= RST_START;
      end
      dwait_q <= RST_WAIT;
      dctrl_q <= RST_CTRL;
      page_q <= RST_PAGE;
      boot_load_q <= 1'b1;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_d;
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      start_q <= start_d;
      dwait_q <= dwait_d;
      dctrl_q <= dctrl_d;
      page_q <= page_d;
      boot_load_q <= boot_load_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  logic [23:0] cur_addr_q, cur_addr_d;
  logic [3:0] hit;
  logic [15:0] cmp_mask [NUM_SPACES];

  always_comb begin
    // a23..a21 always compared for space 0; a23,a22 for 1; a23 for 2,3
    cmp_mask[0] = {3'b000, mask_q[0][7:2], {6{mask_q[0][1]}}, mask_q[0][0]};
    cmp_mask[1] = {2'b00, mask_q[1][7:2], {7{mask_q[1][1]}}, mask_q[1][0]};
    cmp_mask[2] = {1'b0, mask_q[2], 7'h7F};
    cmp_mask[3] = {1'b0, mask_q[3], 7'h7F};
  end

  for (genvar g = 0; g < NUM_SPACES; g++) begin : g_dec
    space_decoder u_dec (
      .addr(cur_addr_d),
      .start_bits(start_q[g]),
      .compare_mask(cmp_mask[g]),
      .enable(ctrl_q[g][CTRL_EN_BIT]),
      .whole_range(g == BOOT_SPACE && !ctrl_q[g][CTRL_PROG_BIT]),
      .hit(hit[g])
    );
  end

  space_cfg_t cfg;
  always_comb begin
    cfg.sel = SEL_DEFAULT;
    cfg.wait_code = req.write ? dwait_q[WW_LSB +: 3] : dwait_q[WR_LSB +: 3];
    cfg.bus_width = dctrl_q[CTRL_BUS_LSB +: 2];
    cfg.recovery = dctrl_q[CTRL_REC_BIT];
    cfg.page = 1'b0;
    for (int i = NUM_SPACES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        // descending loop leaves the lowest hit, giving space 0 priority
        cfg.sel = 3'(i);
        cfg.wait_code = req.write ? wait_q[i][WW_LSB +: 3] : wait_q[i][WR_LSB +: 3];
        cfg.bus_width = ctrl_q[i][CTRL_BUS_LSB +: 2];
        cfg.recovery = ctrl_q[i][CTRL_REC_BIT];
        cfg.page = (i == BOOT_SPACE) && page_q[PAGE_EN_BIT] && !req.write;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer
  bus_state_t state_q, state_d;
  space_cfg_t cyc_q, cyc_d;
  logic [2:0] last_sel_q, last_sel_d;
  logic [2:0] left_q, left_d;
  logic [1:0] idx_q, idx_d;
  logic wr_q;
  logic [31:0] wdat_q, rbuf_q, rbuf_d;
  logic in_page_q, in_page_d;
  logic cyc_start, cyc_last, beat_wide;
  logic [1:0] beat_bytes;
  logic [5:0] page_mask;

  assign bus_busy = (state_q != ST_IDLE);
  assign req_ready = (state_q == ST_IDLE);

  always_comb begin
    case (page_q[PAGE_SIZE_LSB +: 2])
      2'h0: page_mask = 6'h3F;
      2'h1: page_mask = 6'h1F;
      2'h2: page_mask = 6'h0F;
      default: page_mask = 6'h07;
    endcase
  end

  // 16 bit beat only for an even address with two or more bytes left
  assign beat_wide = (cyc_q.bus_width == BUS_16) && !cur_addr_q[0] && (left_q >= 3'h2);
  assign beat_bytes = beat_wide ? 2'h2 : 2'h1;

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    last_sel_d = last_sel_q;
    left_d = left_q;
    idx_d = idx_q;
    cur_addr_d = cur_addr_q;
    rbuf_d = rbuf_q;
    in_page_d = in_page_q;
    cyc_start = 1'b0;
    if (state_q == ST_IDLE) begin
      cur_addr_d = req.addr;
    end
    case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          cyc_d = cfg;
          left_d = 3'h1 << req.size;
          idx_d = 2'h0;
          rbuf_d = 32'h0000_0000;
          in_page_d = 1'b0; // a new access may sit in another page
          if (cfg.recovery && last_sel_q != cfg.sel) begin
            state_d = ST_RECOVER;
          end else begin
            state_d = ST_ACCESS;
            cyc_start = 1'b1;
          end
        end
      end
      ST_RECOVER: begin
        state_d = ST_ACCESS;
        cyc_start = 1'b1;
      end
      ST_ACCESS: begin
        if (cyc_last) begin
          for (int b = 0; b < 2; b++) begin
            if (b < 32'(beat_bytes)) begin
              rbuf_d[8 * (32'(idx_q) + b) +: 8] =
                ext_data_in[8 * (b + ((cyc_q.bus_width == BUS_16 && cur_addr_q[0]) ? 1 : 0)) +: 8];
            end
          end
          last_sel_d = cyc_q.sel;
          // the next beat is a fast page read unless it crosses into a new page
          in_page_d = cyc_q.page && ((cur_addr_q[5:0] & page_mask) != page_mask) &&
                      !(beat_wide && (((cur_addr_q[5:0] + 6'h1) & page_mask) == page_mask));
          cur_addr_d = cur_addr_q + 24'(beat_bytes);
          left_d = left_q - 3'(beat_bytes);
          idx_d = idx_q + beat_bytes;
          state_d = (left_q == 3'(beat_bytes)) ? ST_IDLE : ST_NEXT;
        end
      end
      default: begin
        state_d = ST_ACCESS;
        cyc_start = 1'b1;
      end
    endcase
  end

  wait_counter u_wait (
    .mclk(mclk),
    .rstn(rstn),
    .start(cyc_start),
    .code(cyc_q.wait_code),
    .page_fast(in_page_q && cyc_q.page),
    .page_code(page_q[PAGE_CYC_LSB +: 2]),
    .wait_n(wait_n),
    .last(cyc_last)
  );

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cyc_q <= '0;
      last_sel_q <= SEL_DEFAULT;
      left_q <= 3'h0;
      idx_q <= 2'h0;
      cur_addr_q <= 24'h00_0000;
      rbuf_q <= 32'h0000_0000;
      in_page_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      last_sel_q <= last_sel_d;
      left_q <= left_d;
      idx_q <= idx_d;
      cur_addr_q <= cur_addr_d;
      rbuf_q <= rbuf_d;
      in_page_q <= in_page_d;
      if (state_q == ST_IDLE && req_valid) begin
        wr_q <= req.write;
        wdat_q <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins; strobes drop with ST_ACCESS so the counter's state 1 aligns
  logic active;
  logic [31:0] wsh;
  assign active = (state_q == ST_ACCESS);
  assign wsh = wdat_q >> (8 * 32'(idx_q));

  always_comb begin
    ext_addr = cur_addr_q;
    ext_data_out = 16'h0000;
    ext_data_oe = 2'b00;
    wr_n = 2'b11;
    rd_n = 1'b1;
    space_select_out_n = 4'hF;
    if (active) begin
      if (cyc_q.sel != SEL_DEFAULT) begin
        space_select_out_n[cyc_q.sel[1:0]] = 1'b0;
      end
      if (wr_q) begin
        if (beat_wide) begin
          ext_data_out = wsh[15:0];
          ext_data_oe = 2'b11;
          wr_n = 2'b00;
        end else if (cyc_q.bus_width == BUS_16 && cur_addr_q[0]) begin
          ext_data_out = {wsh[7:0], 8'h00};
          ext_data_oe = 2'b10;
          wr_n = 2'b01;
        end else begin
          ext_data_out = {8'h00, wsh[7:0]};
          ext_data_oe = 2'b01;
          wr_n = 2'b10;
        end
      end else begin
        rd_n = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= active && cyc_last && !wr_q && (left_q == 3'(beat_bytes));
      if (active && cyc_last && (left_q == 3'(beat_bytes))) begin
        rdata <= rbuf_d;
      end
    end
  end
endmodule // memory_controller

// File: memory_controller_chk.sv
module memory_controller_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic req_ready,
  input wire logic rdata_valid,
  input wire logic [1:0] ext_data_oe,
  input wire logic rd_n,
  input wire logic [1:0] wr_n,
  input wire logic [3:0] space_select_out_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property ($rose(rstn) |-> rd_n && wr_n == 2'h3 && space_select_out_n == 4'hF)
    else $error("strobe or select active at reset release");
  a_write_lanes: assert property ((~wr_n & ~ext_data_oe) == 2'h0)
    else $error("write strobe on a floated lane");
  a_read_float: assert property (!rd_n |-> ext_data_oe == 2'h0)
    else $error("data driven during read");
  a_read_min: assert property ($fell(rd_n) && $past(rd_n, 2) |=> !rd_n)
    else $error("read cycle shorter than two states");
  a_write_min: assert property ($fell(&wr_n) |=> !(&wr_n))
    else $error("write cycle shorter than two states");
  a_one_select: assert property ($countones(~space_select_out_n) <= 1)
    else $error("more than one select active");
  a_select_steady: assert property (!rd_n && $past(!rd_n) |-> $stable(space_select_out_n))
    else $error("select moved inside a read");
  a_select_release: assert property ($rose(rd_n) |-> space_select_out_n == 4'hF)
    else $error("select held after cycle end");
  a_valid_pulse: assert property (rdata_valid |-> $past(!rd_n) ##1 !rdata_valid)
    else $error("read data valid out of place");
  a_busy_strobe: assert property (!rd_n || !(&wr_n) |-> !req_ready)
    else $error("request accepted during a bus cycle");
  c_read: cover property (rdata_valid);
  c_long_read: cover property (!rd_n [*6]);
  c_write: cover property (!(&wr_n));
endmodule // memory_controller_chk

bind memory_controller memory_controller_chk memory_controller_chk_i (
  .mclk(mclk),
  .rstn(rstn),
  .req_ready(req_ready),
  .rdata_valid(rdata_valid),
  .ext_data_oe(ext_data_oe),
  .rd_n(rd_n),
  .wr_n(wr_n),
  .space_select_out_n(space_select_out_n)
);

// File: ext_memory_model.sv
module ext_memory_model (
  input wire logic mclk,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_data_out,
  input wire logic [1:0] ext_data_oe,
  input wire logic rd_n,
  input wire logic [1:0] wr_n,
  input wire logic wide,
  input wire logic [3:0] slow,
  output logic [15:0] ext_data_in,
  output logic wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:1023];
  logic [9:0] lo, hi;
  logic [15:0] last = 16'h0;
  logic [23:0] addr_q = 24'h0;
  logic act_q = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic act;
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'hA5;
  end
  always_comb begin
    act = !rd_n || wr_n != 2'h3;
    lo = wide ? {ext_addr[9:1], 1'b0} : ext_addr[9:0];
    hi = {ext_addr[9:1], 1'b1};
  end
  // released bus shows inverted stale data, never a held copy
  assign ext_data_in = rd_n ? ~last : {wide ? mem[hi] : ~mem[lo], mem[lo]};
  // wait goes low from the second state of each beat and releases when done
  assign wait_n = (cnt == 4'h0);
  always @(posedge mclk) begin
    if (act && (!act_q || ext_addr != addr_q)) cnt <= slow;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    act_q <= act;
    addr_q <= ext_addr;
    if (!rd_n) last <= {mem[hi], mem[lo]};
    if (!wr_n[0] && ext_data_oe[0]) mem[lo] <= ext_data_out[7:0];
    if (!wr_n[1] && ext_data_oe[1]) mem[hi] <= ext_data_out[15:8];
  end
endmodule // ext_memory_model

// File: external_memory_chip_select_controller_bench.sv
module external_memory_chip_select_controller_bench;
  import memctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0, wide = 1'b1;
  logic [1:0] boot_mode_pins = 2'h1, htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [2:0] hsize = 3'h2;
  mem_req_t req = '0;
  logic [3:0] slow = 4'h0;
  logic [31:0] hrdata, rdata;
  logic hreadyout, hresp, req_ready, rdata_valid, rd_n, wait_n;
  logic [23:0] ext_addr, a;
  logic [15:0] ext_data_out, ext_data_in, e;
  logic [1:0] ext_data_oe, wr_n;
  logic [3:0] space_select_out_n, sel_seen;
  int mismatches = 0, n_compared = 0, cycles = 0, gap, act, r;
  logic tracking = 1'b0, seen, rd_phase = 1'b0;
  logic [63:0] m;
  logic [31:0] ahb_q[$];
  logic [63:0] data_q[$];
  logic [15:0] len_q[$];
  logic [2:0] codes [5] = '{WAIT_2ST, WAIT_3ST, WAIT_4ST, WAIT_5ST, WAIT_6ST};
  always #4 mclk = ~mclk;
  memory_controller memory_controller_i (.mclk(mclk), .rstn(rstn), .boot_mode_pins(boot_mode_pins), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .rdata(rdata), .rdata_valid(rdata_valid), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .rd_n(rd_n), .wr_n(wr_n), .wait_n(wait_n),
    .space_select_out_n(space_select_out_n));
  ext_memory_model ext_memory_model_i (.mclk(mclk), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .rd_n(rd_n), .wr_n(wr_n), .wide(wide), .slow(slow), .ext_data_in(ext_data_in),
    .wait_n(wait_n));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
    n_compared++;
    if (seen_v !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen_v);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] pat(input logic [23:0] ad);
    for (int k = 0; k < 4; k++) pat[8*k +: 8] = (ad[7:0] + 8'(k)) ^ 8'hA5;
  endfunction
  function automatic logic [7:0] sp(input int i, input logic [7:0] o);
    return o + 8'(i) * OFS_SPACE_STRIDE;
  endfunction
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge mclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (!hreadyout);
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    ahb(1'b1, ad, d);
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] x);
    ahb_q.push_back(x);
    ahb(1'b0, ad, 32'h0);
  endtask
  // one core access; expectations are noted before the request goes out
  task op(input logic [23:0] ad, input logic [1:0] sz, input logic w, input logic [3:0] sel, input logic [3:0] g,
          input logic [7:0] n, input logic [31:0] d);
    len_q.push_back({sel, g, n});
    if (!w) data_q.push_back({sz == 2'h0 ? 32'hFF : sz == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF, d});
    req <= {ad, sz, w, d};
    req_valid <= 1'b1;
    do @(negedge mclk); while (!req_ready);
    @(posedge mclk);
    req_valid <= 1'b0;
    do @(negedge mclk); while (tracking);
    @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (rd_phase && hreadyout) check("hrdata", hrdata, ahb_q.pop_front());
    if (rd_phase && hreadyout) check("hresp", {31'h0, hresp}, 32'h0);
    rd_phase = hsel && htrans[1] && !hwrite && hreadyout;
    if (tracking) begin
      if (!rd_n || wr_n != 2'h3) begin
        if (!seen) sel_seen = space_select_out_n;
        seen = 1'b1;
        act = act + 1;
      end else if (!seen) gap = gap + 1;
      if (seen && req_ready) begin
        tracking = 1'b0;
        e = len_q.pop_front();
        check("select", {28'h0, sel_seen}, {28'h0, e[15:12]});
        check("gap", gap, {28'h0, e[11:8]});
        check("states", act, {24'h0, e[7:0]});
      end
    end
    if (req_valid && req_ready) begin
      tracking = 1'b1;
      seen = 1'b0;
      gap = 0;
      act = 0;
    end
    if (rdata_valid) begin
      m = data_q.pop_front();
      check("rdata", rdata & m[63:32], m[31:0] & m[63:32]);
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(32'h573F9424);
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      rd(sp(i, OFS_SPACE_START0), {24'h0, RST_START});
      rd(sp(i, OFS_SPACE_MASK0), {24'h0, RST_MASK});
    end
    rd(OFS_PAGE_ROM_CTRL, {24'h0, RST_PAGE});
    rd(OFS_SPACE_WAIT0, 32'h0);
    rd(8'h80, 32'h0);
    wr(sp(1, OFS_SPACE_START0), 32'h5A);
    rd(sp(1, OFS_SPACE_START0), 32'h5A);
    op(24'h10, 2'h0, 1'b0, 4'hB, 4'h0, 8'd3, pat(24'h10));
    op(24'h10, 2'h2, 1'b0, 4'hB, 4'h0, 8'd6, pat(24'h10));
    op(24'h11, 2'h1, 1'b0, 4'hB, 4'h0, 8'd6, pat(24'h11));
    op(24'h40, 2'h2, 1'b1, 4'hB, 4'h0, 8'd6, 32'hC3A51E77);
    op(24'h40, 2'h2, 1'b0, 4'hB, 4'h0, 8'd6, 32'hC3A51E77);
    op(24'h51, 2'h0, 1'b1, 4'hB, 4'h0, 8'd3, 32'hE1);
    op(24'h50, 2'h1, 1'b0, 4'hB, 4'h0, 8'd3, 32'hE1F5);
    for (int i = 0; i < 5; i++) begin
      wr(sp(2, OFS_SPACE_WAIT0), {24'h0, 1'b0, WAIT_6ST, 1'b0, codes[i]});
      op(24'h10, 2'h0, 1'b0, 4'hB, 4'h0, 8'(i + 2), pat(24'h10));
      op(24'h52, 2'h0, 1'b1, 4'hB, 4'h0, 8'd6, 32'h0);
    end
    wr(sp(2, OFS_SPACE_WAIT0), {24'h0, 1'b0, WAIT_PIN, 1'b0, WAIT_PIN});
    for (int s = 0; s < 6; s += 3) begin
      slow <= 4'(s);
      op(24'h10, 2'h0, 1'b0, 4'hB, 4'h0, 8'(s + 2), pat(24'h10));
    end
    slow <= 4'h5;
    op(24'h52, 2'h0, 1'b1, 4'hB, 4'h0, 8'd7, 32'h0);
    slow <= 4'h0;
    wide <= 1'b0;
    wr(sp(2, OFS_SPACE_CTRL0), 32'h80);
    wr(sp(2, OFS_SPACE_WAIT0), 32'h22);
    op(24'h40, 2'h2, 1'b0, 4'hB, 4'h0, 8'd12, 32'hC3A51E77);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PAGE_ROM_CTRL, 32'h10 | i);
      a = 24'(32'h100 + (32 >> i) - 2);
      op(a, 2'h2, 1'b0, 4'hB, 4'h0, 8'd6, pat(a));
    end
    op(24'h106, 2'h2, 1'b0, 4'hB, 4'h0, 8'd8, pat(24'h106));
    wr(sp(2, OFS_SPACE_WAIT0), 32'h55);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_PAGE_ROM_CTRL, 32'h10 | (k << 2));
      op(24'h100, 2'h2, 1'b0, 4'hB, 4'h0, 8'(7 + 3 * k), pat(24'h100));
    end
    wr(sp(2, OFS_SPACE_WAIT0), 32'h22);
    wr(sp(0, OFS_SPACE_START0), 32'h12);
    wr(sp(0, OFS_SPACE_MASK0), 32'h02);
    wr(sp(0, OFS_SPACE_CTRL0), 32'h80);
    wr(sp(0, OFS_SPACE_WAIT0), 32'h11);
    op(24'h127E00, 2'h2, 1'b0, 4'hE, 4'h0, 8'd8, pat(24'h127E00));
    wr(OFS_PAGE_ROM_CTRL, 32'h02);
    op(24'h120100, 2'h0, 1'b0, 4'hB, 4'h0, 8'd3, pat(24'h120100));
    wr(sp(0, OFS_SPACE_CTRL0), 32'h90);
    op(24'h120000, 2'h0, 1'b0, 4'hE, 4'h1, 8'd2, pat(24'h120000));
    op(24'h120004, 2'h0, 1'b0, 4'hE, 4'h0, 8'd2, pat(24'h120004));
    wr(sp(0, OFS_SPACE_CTRL0), 32'h80);
    wr(sp(2, OFS_SPACE_CTRL0), 32'h00);
    op(24'h340000, 2'h0, 1'b0, 4'hF, 4'h0, 8'd3, pat(24'h340000));
    wr(OFS_DEFAULT_WAIT, 32'h77);
    repeat (6) begin
      r = $urandom;
      a = {4'h3, r[18:8], 1'b1, r[7:0]};
      op(a, 2'h0, 1'b0, 4'hF, 4'h0, 8'd6, pat(a));
    end
    conclude;
  end
endmodule // external_memory_chip_select_controller_bench
